// *** rtl/fsc_char_packer.sv ***
// one character per bit for the first count bits, zero beyond
`timescale 1ns/10ps
module fsc_char_packer #(
    parameter int N = 40
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [N-1:0]       bits,
    input  wire logic [5:0]         count,
    output logic [8*N-1:0]          chars
);
    if (N < 1 || N > 63) begin : g_chk
        $error("fsc_char_packer: N out of range");
    end

    typedef struct packed {
        logic [8*N-1:0] chars;
    } fsc_pack_state_t;

    fsc_pack_state_t s_reg;
    fsc_pack_state_t s_next;

    always_comb begin
        s_next = s_reg;
        for (int i = 0; i < N; i++) begin
            s_next.chars[8*i +: 8] = (i < int'(count)) ? fsc_pkg::bit_char(bits[i])
                                                       : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign chars = s_reg.chars;

    pack_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        count != 6'h00 |=> chars[7:0] == fsc_pkg::bit_char($past(bits[0])))
        else $error("first character does not follow its bit");
endmodule

// *** rtl/fsc_mapper.sv ***
// status/control word mapper with fault counters and register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
// Operation
// - status word 1 chars 1-7 show input faults
// - char 8 shows controller link state
// - code 1002: one char per binary input
// - code 1005: ten chars, four input bits each
// - code 1005: status word 3 per contact char
// - control word 1 two chars, bit nibbles
// - control bits 1-4 select bus setpoint
// - control word 2 drives bus-controlled contacts; here in code 1005 only, other codes hold the contacts
// - two independent communication fault counters
// - writing 1 to reset clears both counters
// - counters reachable only via configuration port
// - count each error, zero values meanwhile
// - status and control word 1 always present
module fsc_mapper #(
    parameter int CNT_W = fsc_pkg::CNT_WIDTH
) (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic [7:0]     awaddr,
    input  wire logic           awvalid,
    output logic                awready,
    input  wire logic [31:0]    wdata,
    input  wire logic [3:0]     wstrb,
    input  wire logic           wvalid,
    output logic                wready,
    output logic [1:0]          bresp,
    output logic                bvalid,
    input  wire logic           bready,
    input  wire logic [7:0]     araddr,
    input  wire logic           arvalid,
    output logic                arready,
    output logic [31:0]         rdata,
    output logic [1:0]          rresp,
    output logic                rvalid,
    input  wire logic           rready,
    input  wire logic [6:0]     meas_fault,
    input  wire logic           fieldbus_err,
    input  wire logic           ctrl_link_err,
    input  wire logic [39:0]    bin_in,
    input  wire logic [39:0]    contact_in,
    input  wire logic           ctrl_valid,
    input  wire logic [15:0]    ctrl1_chars,
    input  wire logic [79:0]    ctrl2_chars,
    input  wire logic [31:0]    tx_value_in,
    output logic [63:0]         status1_chars,
    output logic [319:0]        status2_chars,
    output logic [319:0]        status3_chars,
    output logic [3:0]          bus_setpoint_active,
    output logic [39:0]         contact_drive,
    output logic [31:0]         tx_value_out,
    output logic                irq
);
    if (CNT_W < 1 || CNT_W > 32) begin : g_chk
        $error("fsc_mapper: CNT_W out of range");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic           aw_got;
        logic [7:0]     aw_addr;
        logic           w_got;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic           awready;
        logic           wready;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        logic [31:0]    cfg;
        logic [39:0]    bus_mask;
        logic [1:0]     irq_stat;
        logic [1:0]     irq_mask;
        logic           irq;
        logic           cnt_clr;
        logic           fb_err_q;
        logic           ctl_err_q;
        logic [63:0]    status1;
        logic [319:0]   status2;
        logic [3:0]     sp_act;
        logic [39:0]    contact;
        logic [31:0]    tx_value;
    } fsc_state_t;

    fsc_state_t         s_reg;
    fsc_state_t         s_next;
    logic [CNT_W-1:0]   cnt_fb;
    logic [CNT_W-1:0]   cnt_ctl;
    logic [319:0]       bin_chars;
    logic [319:0]       con_chars;
    logic [5:0]         bin_count;
    logic [5:0]         con_count;
    logic               fb_rise;
    logic               ctl_rise;
    logic               mode_1002;
    logic               mode_1005;

    assign mode_1005 = s_reg.cfg[fsc_pkg::CFG_B1005];
    assign mode_1002 = s_reg.cfg[fsc_pkg::CFG_B1002] && !mode_1005;
    assign bin_count = mode_1002 ? s_reg.cfg[fsc_pkg::CFG_NBIN_LSB +: 6] : 6'h00;
    assign con_count = mode_1005 ? s_reg.cfg[fsc_pkg::CFG_NCON_LSB +: 6] : 6'h00;
    assign fb_rise   = fieldbus_err && !s_reg.fb_err_q;
    assign ctl_rise  = ctrl_link_err && !s_reg.ctl_err_q;

    // ****************************************
    // fault counters and character packers
    // ****************************************
    fsc_sat_counter #(.W(CNT_W)) u_cnt_fb (
        .clk   (clk),
        .rst_n (rst_n),
        .inc   (fb_rise),
        .clr   (s_reg.cnt_clr),
        .count (cnt_fb)
    );

    fsc_sat_counter #(.W(CNT_W)) u_cnt_ctl (
        .clk   (clk),
        .rst_n (rst_n),
        .inc   (ctl_rise),
        .clr   (s_reg.cnt_clr),
        .count (cnt_ctl)
    );

    fsc_char_packer #(.N(fsc_pkg::NUM_BITS)) u_pack_bin (
        .clk   (clk),
        .rst_n (rst_n),
        .bits  (bin_in),
        .count (bin_count),
        .chars (bin_chars)
    );

    fsc_char_packer #(.N(fsc_pkg::NUM_BITS)) u_pack_con (
        .clk   (clk),
        .rst_n (rst_n),
        .bits  (contact_in),
        .count (con_count),
        .chars (con_chars)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [39:0] ctl_bits;
        ctl_bits = s_reg.contact;
        s_next = s_reg;
        s_next.cnt_clr = 1'b0;
        // bus write channels, either order
        if (awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        if (s_reg.bvalid && bready) s_next.bvalid = 1'b0;
        if (s_next.aw_got && s_next.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = fsc_pkg::RESP_OKAY;
            case (s_next.aw_addr)
                fsc_pkg::OFS_CFG:
                    s_next.cfg = fsc_pkg::strb_merge(s_reg.cfg, s_next.w_data, s_next.w_strb);
                fsc_pkg::OFS_CNT_RST: begin
                    if (s_next.w_strb[0] && s_next.w_data == fsc_pkg::CNT_RST_CMD) begin
                        s_next.cnt_clr = 1'b1;
                    end
                end
                fsc_pkg::OFS_MSK_LO:
                    s_next.bus_mask[31:0] = fsc_pkg::strb_merge(s_reg.bus_mask[31:0],
                                                                s_next.w_data, s_next.w_strb);
                fsc_pkg::OFS_MSK_HI:
                    if (s_next.w_strb[0]) s_next.bus_mask[39:32] = s_next.w_data[7:0];
                fsc_pkg::OFS_IRQ_MASK:
                    if (s_next.w_strb[0]) s_next.irq_mask = s_next.w_data[1:0];
                fsc_pkg::OFS_CNT_FB, fsc_pkg::OFS_CNT_CTL, fsc_pkg::OFS_IRQ_STAT: ;
                default: s_next.bresp = fsc_pkg::RESP_SLVERR;
            endcase
        end
        // bus read channel
        if (s_reg.rvalid && rready) s_next.rvalid = 1'b0;
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = fsc_pkg::RESP_OKAY;
            s_next.rdata = 32'h0000_0000;
            case (araddr)
                fsc_pkg::OFS_CFG:      s_next.rdata = s_reg.cfg;
                fsc_pkg::OFS_CNT_FB:   s_next.rdata[CNT_W-1:0] = cnt_fb;
                fsc_pkg::OFS_CNT_CTL:  s_next.rdata[CNT_W-1:0] = cnt_ctl;
                fsc_pkg::OFS_MSK_LO:   s_next.rdata = s_reg.bus_mask[31:0];
                fsc_pkg::OFS_MSK_HI:   s_next.rdata[7:0] = s_reg.bus_mask[39:32];
                fsc_pkg::OFS_IRQ_MASK: s_next.rdata[1:0] = s_reg.irq_mask;
                fsc_pkg::OFS_IRQ_STAT: begin
                    s_next.rdata[1:0] = s_reg.irq_stat;
                    s_next.irq_stat = 2'h0;
                end
                fsc_pkg::OFS_CNT_RST: ;
                default: s_next.rresp = fsc_pkg::RESP_SLVERR;
            endcase
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready  = !s_next.w_got && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
        // sticky events, set wins over read clear
        s_next.irq_stat[fsc_pkg::IRQ_FB]  = s_next.irq_stat[fsc_pkg::IRQ_FB] | fb_rise;
        s_next.irq_stat[fsc_pkg::IRQ_CTL] = s_next.irq_stat[fsc_pkg::IRQ_CTL] | ctl_rise;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
        s_next.fb_err_q = fieldbus_err;
        s_next.ctl_err_q = ctrl_link_err;
        // status word 1, always present
        for (int i = 0; i < fsc_pkg::NUM_MEAS; i++) begin
            s_next.status1[8*i +: 8] = fsc_pkg::bit_char(meas_fault[i]);
        end
        s_next.status1[63:56] = fsc_pkg::bit_char(!ctrl_link_err);
        // status word 2
        s_next.status2 = '0;
        if (mode_1005) begin
            for (int k = 0; k < fsc_pkg::NUM_NIB; k++) begin
                s_next.status2[8*k +: 8] = fsc_pkg::hex_enc(bin_in[4*k +: 4]);
            end
        end else if (mode_1002) begin
            s_next.status2 = bin_chars;
        end
        // control words
        if (ctrl_valid) begin
            s_next.sp_act = fsc_pkg::hex_dec(ctrl1_chars[15:8]);
            if (mode_1005) begin
                for (int k = 0; k < fsc_pkg::NUM_NIB; k++) begin
                    ctl_bits[4*k +: 4] = fsc_pkg::hex_dec(ctrl2_chars[8*k +: 8]);
                end
            end
        end
        s_next.contact = ctl_bits & s_reg.bus_mask;
        s_next.tx_value = (fieldbus_err || ctrl_link_err) ? 32'h0000_0000
                                                          : tx_value_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign awready             = s_reg.awready;
    assign wready              = s_reg.wready;
    assign bvalid              = s_reg.bvalid;
    assign bresp               = s_reg.bresp;
    assign arready             = s_reg.arready;
    assign rvalid              = s_reg.rvalid;
    assign rdata               = s_reg.rdata;
    assign rresp               = s_reg.rresp;
    assign status1_chars       = s_reg.status1;
    assign status2_chars       = s_reg.status2;
    assign status3_chars       = con_chars;
    assign bus_setpoint_active = s_reg.sp_act;
    assign contact_drive       = s_reg.contact;
    assign tx_value_out        = s_reg.tx_value;
    assign irq                 = s_reg.irq;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    meas_char_a: assert property (meas_fault[0] |=> status1_chars[7:0] == 8'h31)
        else $error("fault not shown in char 1");
    link_char_a: assert property (ctrl_link_err |=> status1_chars[63:56] == 8'h30)
        else $error("link failure not shown in char 8");
    nib_pack_a: assert property (mode_1005 && $stable(s_reg.cfg) |=>
        status2_chars[79:72] == fsc_pkg::hex_enc($past(bin_in[39:36])))
        else $error("char 10 does not hold bits 40..37");
    sp_select_a: assert property (ctrl_valid |=>
        bus_setpoint_active == fsc_pkg::hex_dec($past(ctrl1_chars[15:8])))
        else $error("setpoint select not taken from char 2");
    contact_mask_a: assert property ((contact_drive & ~$past(s_reg.bus_mask)) == 40'h0)
        else $error("contact driven without bus control");
    tx_zero_a: assert property (fieldbus_err || ctrl_link_err |=> tx_value_out == 32'h0)
        else $error("value sent during error");
    cnt_reset_a: assert property (s_reg.cnt_clr |=>
        cnt_fb <= CNT_W'(1) && cnt_ctl <= CNT_W'(1))
        else $error("counters not cleared together");
    fb_count_a: assert property (fb_rise && !s_reg.cnt_clr && cnt_fb != '1 |=>
        cnt_fb == $past(cnt_fb) + CNT_W'(1))
        else $error("fieldbus fault not counted");
endmodule

// *** rtl/fsc_pkg.sv ***
// shared constants, encodings and helpers of the status/control word mapper
package fsc_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int          NUM_BITS     = 40;
    localparam int          NUM_NIB      = 10;
    localparam int          NUM_MEAS     = 7;
    localparam int          CNT_WIDTH    = 16;
    // ****************************************
    // character codes
    // ****************************************
    localparam logic [7:0]  CHR_ZERO     = 8'h30;
    localparam logic [7:0]  CHR_ONE      = 8'h31;
    localparam logic [7:0]  CHR_NINE     = 8'h39;
    localparam logic [7:0]  CHR_UP_A     = 8'h41;
    localparam logic [7:0]  CHR_UP_F     = 8'h46;
    localparam logic [7:0]  CHR_LO_A     = 8'h61;
    localparam logic [7:0]  CHR_LO_F     = 8'h66;
    localparam logic [7:0]  CHR_HEX_OFS  = 8'h37;
    localparam logic [7:0]  CHR_LO_OFS   = 8'h57;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  OFS_CFG      = 8'h00;
    localparam logic [7:0]  OFS_CNT_RST  = 8'h04;
    localparam logic [7:0]  OFS_CNT_FB   = 8'h08;
    localparam logic [7:0]  OFS_CNT_CTL  = 8'h0c;
    localparam logic [7:0]  OFS_MSK_LO   = 8'h10;
    localparam logic [7:0]  OFS_MSK_HI   = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h1c;
    localparam int          CFG_B1002    = 0;
    localparam int          CFG_B1005    = 1;
    localparam int          CFG_NBIN_LSB = 8;
    localparam int          CFG_NCON_LSB = 16;
    localparam logic [31:0] CFG_RST      = 32'h0000_0000;
    localparam logic [31:0] CNT_RST_CMD  = 32'h0000_0001;
    localparam int          IRQ_FB       = 0;
    localparam int          IRQ_CTL      = 1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // '1' or '0' for one bit
    function automatic logic [7:0] bit_char(input logic b);
        return b ? CHR_ONE : CHR_ZERO;
    endfunction

    // nibble to hex digit character
    function automatic logic [7:0] hex_enc(input logic [3:0] n);
        return (n > 4'h9) ? 8'({4'h0, n}) + CHR_HEX_OFS : 8'({4'h0, n}) + CHR_ZERO;
    endfunction

    // hex digit character to nibble, anything else gives zero
    function automatic logic [3:0] hex_dec(input logic [7:0] c);
        logic [7:0] v;
        v = 8'h00;
        if (c >= CHR_ZERO && c <= CHR_NINE) v = c - CHR_ZERO;
        else if (c >= CHR_UP_A && c <= CHR_UP_F) v = c - CHR_HEX_OFS;
        else if (c >= CHR_LO_A && c <= CHR_LO_F) v = c - CHR_LO_OFS;
        return v[3:0];
    endfunction

    // byte-lane merge of a bus write
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] din,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) if (strb[i]) r[8*i +: 8] = din[8*i +: 8];
        return r;
    endfunction
endpackage

// *** rtl/fsc_sat_counter.sv ***
// saturating fault counter with synchronous clear
`timescale 1ns/10ps
module fsc_sat_counter #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         inc,
    input  wire logic         clr,
    output logic [W-1:0]      count
);
    if (W < 1 || W > 32) begin : g_chk
        $error("fsc_sat_counter: W out of range");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
    } fsc_cnt_state_t;

    fsc_cnt_state_t s_reg;
    fsc_cnt_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (clr) begin
            s_next.cnt = inc ? W'(1) : '0;
        end else if (inc && s_reg.cnt != '1) begin
            s_next.cnt = s_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign count = s_reg.cnt;

    cnt_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
        inc && !clr && count != '1 |=> count == $past(count) + W'(1))
        else $error("fault counter did not step");
    cnt_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
        count == '1 && !clr |=> count == '1)
        else $error("fault counter wrapped");
    cnt_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        clr |=> count <= W'(1))
        else $error("fault counter not cleared");
endmodule

// *** verification/fsc_mapper_test.sv ***
// self-checking bench of the status/control word mapper
`timescale 1ns/10ps
module fsc_mapper_test;
    localparam int CW = 2;
    logic         clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready, ctrl_valid, irq, send;
    logic         fieldbus_err, ctrl_link_err;
    logic [7:0]   awaddr, araddr, cw1_bits;
    logic [31:0]  wdata, rdata, tx_value_in, tx_value_out, rd;
    logic [3:0]   wstrb, bus_setpoint_active;
    logic [1:0]   bresp, rresp, rsp;
    logic [6:0]   meas_fault;
    logic [39:0]  bin_in, contact_in, contact_drive, cw2_bits, msk;
    logic [15:0]  ctrl1_chars;
    logic [79:0]  ctrl2_chars;
    logic [63:0]  status1_chars;
    logic [319:0] status2_chars, status3_chars, exp2, exp3;
    int           num_errors, checks, nb, lim;

    fsc_mapper #(.CNT_W(CW)) i_dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .meas_fault, .fieldbus_err, .ctrl_link_err,
        .bin_in, .contact_in, .ctrl_valid, .ctrl1_chars, .ctrl2_chars, .tx_value_in,
        .status1_chars, .status2_chars, .status3_chars, .bus_setpoint_active,
        .contact_drive, .tx_value_out, .irq);
    fsc_master_model i_far (.clk, .send, .cw1_bits, .cw2_bits, .ctrl_valid,
        .ctrl1_chars, .ctrl2_chars);

    always #2 clk = ~clk;

    function automatic logic [7:0] bc(input logic b);
        return b ? 8'h31 : 8'h30;
    endfunction
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n > 4'h9) ? 8'h37 + 8'(n) : 8'h30 + 8'(n);
    endfunction
    task automatic chk(input logic [319:0] seen, input logic [319:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 64);
        r = bresp;
        bready <= 1'b0;
        if (n >= 64) begin
            num_errors++;
            results();
        end
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 64) begin
            num_errors++;
            results();
        end
    endtask
    task automatic stir();
        meas_fault <= 7'($urandom);
        bin_in <= 40'({$urandom, $urandom});
        contact_in <= 40'({$urandom, $urandom});
        tx_value_in <= $urandom;
        tick(3);
    endtask

    initial begin
        {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, send} = '0;
        {fieldbus_err, ctrl_link_err, awaddr, araddr, cw1_bits, wdata} = '0;
        {meas_fault, bin_in, contact_in, cw2_bits, tx_value_in} = '0;
        wstrb = 4'hf;
        num_errors = 0;
        checks = 0;
        lim = (1 << CW) - 1;
        rd = $urandom(32'hcde1f0b7);
        tick(20);
        rst_n <= 1'b1;
        tick(2);
        for (int a = 0; a < 40; a += 4) begin
            rdr(8'(a), rd, rsp);
            chk(rsp, (a < 32) ? 2'h0 : 2'h2);
            chk(rd, 0);
        end
        for (int m = 0; m < 4; m++) begin
            nb = (m == 2) ? 40 : $urandom_range(39, 1);
            wr(8'h00, 32'((nb << 16) | (nb << 8) | m), rsp);
            repeat (4) begin
                stir();
                exp2 = '0;
                exp3 = '0;
                for (int i = 0; i < 40; i++) begin
                    if (m == 1 && i < nb) exp2[8*i +: 8] = bc(bin_in[i]);
                    if (m >= 2 && i < 10) exp2[8*i +: 8] = hx(bin_in[4*i +: 4]);
                    if (m >= 2 && i < nb) exp3[8*i +: 8] = bc(contact_in[i]);
                end
                for (int i = 0; i < 7; i++) begin
                    chk(status1_chars[8*i +: 8], bc(meas_fault[i]));
                end
                chk(status1_chars[63:56], 8'h31);
                chk(status2_chars, exp2);
                chk(status3_chars, exp3);
                chk(tx_value_out, tx_value_in);
            end
        end
        msk = 40'({$urandom, $urandom});
        wr(8'h10, msk[31:0], rsp);
        wr(8'h14, {24'h0, msk[39:32]}, rsp);
        repeat (6) begin
            cw1_bits <= 8'($urandom);
            cw2_bits <= 40'({$urandom, $urandom});
            send <= 1'b1;
            tick(1);
            send <= 1'b0;
            tick(3);
            chk(bus_setpoint_active, cw1_bits[3:0]);
            chk(contact_drive, cw2_bits & msk);
        end
        wr(8'h24, 32'hffff_ffff, rsp);
        chk(rsp, 2'h2);
        wr(8'h1c, 32'h1, rsp);
        chk(rsp, 2'h0);
        for (int k = 0; k < 5; k++) begin
            fieldbus_err <= 1'b1;
            tick(2);
            chk(tx_value_out, 0);
            fieldbus_err <= 1'b0;
            tick(2);
        end
        chk(irq, 1'b1);
        ctrl_link_err <= 1'b1;
        tick(3);
        chk(status1_chars[63:56], 8'h30);
        rdr(8'h18, rd, rsp);
        chk(rd, 32'h3);
        tick(2);
        chk(irq, 1'b0);
        rdr(8'h08, rd, rsp);
        chk(rd, (5 > lim) ? lim : 5);
        rdr(8'h0c, rd, rsp);
        chk(rd, 1);
        wr(8'h04, 32'h1, rsp);
        chk(rsp, 2'h0);
        tick(3);
        rdr(8'h08, rd, rsp);
        chk(rd, 0);
        rdr(8'h0c, rd, rsp);
        chk(rd, 0);
        results();
    end
endmodule

// *** verification/fsc_master_model.sv ***
// far-side model: cyclic master frames carrying the control words
`timescale 1ns/10ps
module fsc_master_model (
    input  wire logic        clk,
    input  wire logic        send,
    input  wire logic [7:0]  cw1_bits,
    input  wire logic [39:0] cw2_bits,
    output logic             ctrl_valid,
    output logic [15:0]      ctrl1_chars,
    output logic [79:0]      ctrl2_chars
);
    function automatic logic [7:0] nib_char(input logic [3:0] n);
        return (n > 4'h9) ? 8'h37 + 8'(n) : 8'h30 + 8'(n);
    endfunction
    initial begin
        ctrl_valid = 1'b0;
        ctrl1_chars = 16'h0;
        ctrl2_chars = 80'h0;
    end
    // every frame carries control word 1; junk between frames
    always @(posedge clk) begin
        ctrl_valid <= send;
        if (send) begin
            ctrl1_chars <= {nib_char(cw1_bits[3:0]), nib_char(cw1_bits[7:4])};
            for (int k = 0; k < 10; k++) begin
                ctrl2_chars[8*k +: 8] <= nib_char(cw2_bits[4*k +: 4]);
            end
        end else begin
            ctrl1_chars <= ~ctrl1_chars;
            ctrl2_chars <= ~ctrl2_chars;
        end
    end
endmodule
